/* logic/hostwr_cfg.svh */
// Timing constants and field widths shared by both ends of the write port.
// Overview of operation
// - Host ends cycle on handshake or worst time
// - Device drives handshake only under chip select
// - Write completes within 200/280 ns budget
// - Host holds strobe until handshake goes inactive
// - Cycle spans strobe assertion with chip select
// - Chip select never changes while strobe active
// - Handshake output disabled after reset
`ifndef HOSTWR_CFG_SVH
`define HOSTWR_CFG_SVH
`define CLK_PERIOD_NS 10
`define WRITE8_MAX_NS 200
`define WRITE16_MAX_NS 280
`define WRITE8_CYC (`WRITE8_MAX_NS / `CLK_PERIOD_NS)
`define WRITE16_CYC (`WRITE16_MAX_NS / `CLK_PERIOD_NS)
`define INT_WRITE_CYC 8
`define ACK_SETTLE_CYC 4
`define CNT_W 6
`define ADDR_W 16
`define DATA_W 16
`define SYNC_W 2
`define CNT_ZERO 6'h00
`define CNT_ONE 6'h01
`endif

/* logic/hostwr_pkg.sv */
// Types shared by both ends of the non-posted write port.
`include "hostwr_cfg.svh"
package hostwr_pkg;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`DATA_W-1:0] data_t;
  typedef logic [`CNT_W-1:0] cnt_t;
  typedef enum logic [2:0] {
    DS_IDLE = 3'h1,
    DS_BUSY = 3'h2,
    DS_DONE = 3'h4
  } dev_state_t;
  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_SETUP = 4'h2,
    HS_STROBE = 4'h4,
    HS_GAP = 4'h8
  } host_state_t;
endpackage

/* logic/hostwr_if.sv */
// Pin-level interface joining the host and the device write port.
`timescale 1ns/1ns
`include "hostwr_cfg.svh"
interface hostwr_if;
  logic cs_n;
  logic wr_n;
  logic rd_wr;
  logic bus_enable_strobe;
  logic [`ADDR_W-1:0] addr;
  logic [`DATA_W-1:0] data;
  logic wait_ack_o;
  logic wait_ack_oe;
  modport host (
    output cs_n, wr_n, rd_wr, bus_enable_strobe, addr, data,
    input wait_ack_o, wait_ack_oe
  );
  modport device (
    input cs_n, wr_n, rd_wr, bus_enable_strobe, addr, data,
    output wait_ack_o, wait_ack_oe
  );
endinterface

/* logic/hostwr_device.sv */
// Device end: accepts non-posted writes and drives the wait handshake.
`timescale 1ns/1ns
module hostwr_device (
  input wire logic clk,
  input wire logic rstn,
  hostwr_if.device bus,
  input wire logic ack_enable,
  input wire logic wide_bus,
  input wire logic enable_scheme,
  output logic wr_valid,
  output hostwr_pkg::addr_t wr_addr,
  output hostwr_pkg::data_t wr_data,
  output logic budget_overrun
);
  import hostwr_pkg::*;

  logic [`SYNC_W-1:0] cs_s_q, wr_s_q, en_s_q, dir_s_q;
  logic cs_act, strobe_act;
  dev_state_t st_q, st_d;
  cnt_t cnt_q, cnt_d;
  addr_t addr_q, addr_d;
  data_t data_q, data_d;
  logic valid_q, valid_d;
  logic over_q, over_d;
  cnt_t budget;

  // Strobe and select pins are asynchronous to clk, so each passes two flops first.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_s_q <= '0;
      wr_s_q <= '0;
      en_s_q <= '0;
      dir_s_q <= '0;
    end else begin
      cs_s_q <= {cs_s_q[0], ~bus.cs_n};
      wr_s_q <= {wr_s_q[0], ~bus.wr_n};
      en_s_q <= {en_s_q[0], bus.bus_enable_strobe};
      dir_s_q <= {dir_s_q[0], ~bus.rd_wr};
    end
  end

  // Write strobe decode for either signalling scheme.
  assign cs_act = cs_s_q[1];
  assign strobe_act = cs_act & (enable_scheme ?
                      (en_s_q[1] & dir_s_q[1]) : wr_s_q[1]);
  // Wider bus gets the longer budget; the internal write fits either.
  assign budget = wide_bus ? cnt_t'(`WRITE16_CYC) :
                  cnt_t'(`WRITE8_CYC);

  // Next state: latch at strobe, count the internal write, wait release.
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    data_d = data_q;
    valid_d = 1'b0;
    over_d = over_q;
    unique case (st_q)
      DS_IDLE: begin
        if (strobe_act) begin
          st_d = DS_BUSY;
          cnt_d = `CNT_ONE;
          addr_d = bus.addr;
          data_d = bus.data;
        end
      end
      DS_BUSY: begin
        cnt_d = cnt_q + `CNT_ONE;
        if (cnt_q >= cnt_t'(`INT_WRITE_CYC)) begin
          st_d = DS_DONE;
          valid_d = 1'b1;
          over_d = over_q | (cnt_q > budget);
        end
      end
      DS_DONE: begin
        if (!strobe_act) begin
          st_d = DS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= DS_IDLE;
      cnt_q <= `CNT_ZERO;
      addr_q <= '0;
      data_q <= '0;
      valid_q <= 1'b0;
      over_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      data_q <= data_d;
      valid_q <= valid_d;
      over_q <= over_d;
    end
  end

  // Pin is released when disabled, so a grounded board pin never fights.
  assign bus.wait_ack_oe = ack_enable & ~bus.cs_n;
  // Wait is active low: high means the host may finish.
  assign bus.wait_ack_o = ~(st_q == DS_BUSY ||
                          (st_q == DS_IDLE && strobe_act));
  assign wr_valid = valid_q;
  assign wr_addr = addr_q;
  assign wr_data = data_q;
  assign budget_overrun = over_q;
endmodule

/* logic/hostwr_host.sv */
// Host end: runs one non-posted write per request over the parallel pins.
`timescale 1ns/1ns
module hostwr_host (
  input wire logic clk,
  input wire logic rstn,
  hostwr_if.host bus,
  input wire logic use_ack,
  input wire logic wide_bus,
  input wire logic enable_scheme,
  input wire logic req_valid,
  input hostwr_pkg::addr_t req_addr,
  input hostwr_pkg::data_t req_data,
  output logic req_ready,
  output logic done
);
  import hostwr_pkg::*;

  logic [`SYNC_W-1:0] ack_s_q;
  host_state_t st_q, st_d;
  cnt_t cnt_q, cnt_d;
  addr_t addr_q, addr_d;
  data_t data_q, data_d;
  logic done_q, done_d;
  logic ack_ok;
  cnt_t worst;

  // The wait pin is asynchronous here too; treat undriven as not ready.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_s_q <= '0;
    end else begin
      ack_s_q <= {ack_s_q[0], bus.wait_ack_oe & bus.wait_ack_o};
    end
  end

  assign worst = wide_bus ? cnt_t'(`WRITE16_CYC) : cnt_t'(`WRITE8_CYC);
  // Either observe the handshake or sit out the worst-case time.
  // The ready level synchronised before the device saw the strobe is stale
  // for four strobe cycles, so it is ignored until then.
  assign ack_ok = use_ack ?
                  (ack_s_q[1] && cnt_q >= cnt_t'(`ACK_SETTLE_CYC)) :
                  (cnt_q >= worst);

  // Chip select and address settle one cycle before the strobe.
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    data_d = data_q;
    done_d = 1'b0;
    unique case (st_q)
      HS_IDLE: begin
        if (req_valid) begin
          st_d = HS_SETUP;
          addr_d = req_addr;
          data_d = req_data;
        end
      end
      HS_SETUP: begin
        st_d = HS_STROBE;
        cnt_d = `CNT_ZERO;
      end
      HS_STROBE: begin
        cnt_d = cnt_q + `CNT_ONE;
        if (ack_ok) begin
          st_d = HS_GAP;
          done_d = 1'b1;
        end
      end
      HS_GAP: begin
        st_d = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= HS_IDLE;
      cnt_q <= `CNT_ZERO;
      addr_q <= '0;
      data_q <= '0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      data_q <= data_d;
      done_q <= done_d;
    end
  end

  // Chip select spans setup, strobe and gap so it never moves mid-strobe.
  assign bus.cs_n = (st_q == HS_IDLE);
  assign bus.wr_n = !(st_q == HS_STROBE && !enable_scheme);
  assign bus.bus_enable_strobe = (st_q == HS_STROBE) && enable_scheme;
  assign bus.rd_wr = 1'b0;
  assign bus.addr = addr_q;
  assign bus.data = data_q;
  assign req_ready = (st_q == HS_IDLE);
  assign done = done_q;
endmodule

/* verification/hostwr_asserts.sv */
// Checker on the pins joining the host and device ends.
`timescale 1ns/1ns
`include "hostwr_cfg.svh"
module hostwr_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_wr,
  input wire logic bus_enable_strobe,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [`DATA_W-1:0] data,
  input wire logic wait_ack_o,
  input wire logic wait_ack_oe
);
  logic st;
  // Either scheme counts, since the unused strobe rests inactive.
  assign st = !wr_n || (bus_enable_strobe && !rd_wr);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_go;
    $rose(st) && !cs_n;
  endsequence
  sequence s_ack_back;
    ##[3:20] $rose(wait_ack_o);
  endsequence
  chk_oe_under_cs: assert property (wait_ack_oe |-> !cs_n)
    else $error("handshake driven without chip select");
  chk_quiet_reset: assert property (disable iff (1'b0)
    !rstn |-> !wait_ack_oe) else $error("handshake driven in reset");
  chk_ready_first: assert property ($fell(cs_n) |-> wait_ack_o)
    else $error("handshake not inactive at select");
  chk_wait_on_go: assert property (s_go |-> ##[1:4] !wait_ack_o)
    else $error("no wait after strobe");
  chk_write_budget: assert property (s_go |-> s_ack_back)
    else $error("write not done within budget");
  chk_strobe_hold: assert property ($fell(st) |-> $past(wait_ack_o))
    else $error("strobe released during wait");
  chk_pins_steady: assert property (st && $past(st) |->
    $stable(cs_n) && $stable(addr) && $stable(data))
    else $error("select or address moved under strobe");
  chk_wait_in_cycle: assert property (!wait_ack_o |-> st)
    else $error("wait outside write cycle");
endmodule

/* verification/test_host_nonposted_write_handshake.sv */
// Bench joining both ends and checking each non-posted write.
`timescale 1ns/1ns
module test_host_nonposted_write_handshake;
  import hostwr_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  logic use_ack = 0;
  logic wide_bus = 0;
  logic scheme = 0;
  logic req_valid = 0;
  addr_t req_addr = 16'h0000;
  data_t req_data = 16'h0000;
  logic req_ready, done, wr_valid, overrun;
  addr_t wr_addr;
  data_t wr_data;
  int err_count = 0;
  int checks = 0;
  hostwr_if bif ();
  // Free-running clock of 10 ns.
  always #5 clk = ~clk;
  hostwr_host u_hostwr_host (.clk(clk), .rstn(rstn), .bus(bif),
    .use_ack(use_ack), .wide_bus(wide_bus), .enable_scheme(scheme),
    .req_valid(req_valid), .req_addr(req_addr), .req_data(req_data),
    .req_ready(req_ready), .done(done));
  hostwr_device u_hostwr_device (.clk(clk), .rstn(rstn), .bus(bif),
    .ack_enable(use_ack), .wide_bus(wide_bus), .enable_scheme(scheme),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .budget_overrun(overrun));
  hostwr_asserts u_hostwr_asserts (.clk(clk), .rstn(rstn),
    .cs_n(bif.cs_n), .wr_n(bif.wr_n), .rd_wr(bif.rd_wr),
    .bus_enable_strobe(bif.bus_enable_strobe), .addr(bif.addr),
    .data(bif.data), .wait_ack_o(bif.wait_ack_o),
    .wait_ack_oe(bif.wait_ack_oe));
  task automatic print_verdict();
    if (err_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic compare(string what, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Outputs are sampled at the falling edge, where they have settled.
  task automatic write_word(addr_t a, data_t d);
    int n;
    logic oe_seen;
    logic got_v;
    logic got_d;
    oe_seen = 1'b0;
    got_v = 1'b0;
    got_d = 1'b0;
    for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge clk);
    compare("req_ready", 16'h0001, {15'h0000, req_ready});
    if (req_ready !== 1'b1) print_verdict();
    req_valid = 1'b1;
    req_addr = a;
    req_data = d;
    @(negedge clk);
    req_valid = 1'b0;
    for (n = 0; n < 80 && !got_d; n++) begin
      @(negedge clk);
      oe_seen = oe_seen | bif.wait_ack_oe;
      got_v = got_v | wr_valid;
      got_d = got_d | done;
    end
    compare("done", 16'h0001, {15'h0000, got_d});
    compare("wr_valid", 16'h0001, {15'h0000, got_v});
    compare("wr_addr", a, wr_addr);
    compare("wr_data", d, wr_data);
    compare("oe", {15'h0000, use_ack}, {15'h0000, oe_seen});
    if (!got_d) print_verdict();
  endtask
  // Every scheme, width and handshake setting, two writes back to back.
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 8; i++) begin
      {scheme, wide_bus, use_ack} = i[2:0];
      write_word(16'h1000 + addr_t'(i), 16'hA5C3 ^ data_t'(i));
      write_word(16'hFFFF, 16'h0000 - data_t'(i));
    end
    compare("overrun", 16'h0000, {15'h0000, overrun});
    print_verdict();
  end
endmodule
